// file: pkg/cos_consts.svh
// Offsets, field positions, reset values and timing counts of the
// control output stage. Included by the package and by the modules.
`ifndef COS_CONSTS_SVH
`define COS_CONSTS_SVH

`define COS_A_CTRL 8'h00
`define COS_A_FUNC 8'h04
`define COS_A_CYCLE 8'h08
`define COS_A_LIMIT 8'h0c
`define COS_A_HYS_HC 8'h10
`define COS_A_HYS_LIM 8'h14
`define COS_A_PRESET 8'h18
`define COS_A_STATUS 8'h1c

`define COS_F_FWD 0
`define COS_F_STOP 1
`define COS_F_ONOFF 2
`define COS_F_RF1 0
`define COS_F_AF2 4
`define COS_F_AF3 6
`define COS_F_RFA1 8
`define COS_F_RFA2 12
`define COS_F_HLOOP 16
`define COS_F_CLOOP 17
`define COS_F_HI 0
`define COS_F_LO 8
`define COS_F_HYS_UP 0
`define COS_F_HYS_LO 16
`define COS_F_CYC_C 16
`define COS_F_PRE_C 8
`define COS_F_ST_LVH 8
`define COS_F_ST_LVC 16

`define COS_PCT_W 7
`define COS_CYC_W 9
`define COS_CNT_W 15
`define COS_PRE_W 24
`define COS_PV_W 16

`define COS_CYC_DEF 9'h002
`define COS_CYC_MIN 9'h001
`define COS_CYC_MAX 9'h12c
`define COS_PCT_MAX 7'h64
`define COS_LIM_HI_DEF 7'h64
`define COS_LIM_LO_DEF 7'h00
`define COS_PRESET_DEF 7'h00
`define COS_HYS_DEF 16'h0001
`define COS_SLICES 7'h64

`define COS_CLK_NS 25
`define COS_SLICE_NS 10000000
`define COS_SLICE_CYC (`COS_SLICE_NS / `COS_CLK_NS)

`endif

// file: pkg/cos_pkg.sv
// Types of the control output stage.
// Assumes cos_consts.svh is on the include path.
`include "cos_consts.svh"
package cos_pkg;
  typedef enum logic [2:0] {RF_HEAT, RF_COOL, RF_ALARM_ONE, RF_ALARM_TWO,
    RF_ALARM_THREE, RF_RUN} cos_rf_e;
  typedef enum logic [1:0] {AF_HEAT, AF_COOL, AF_RETRANS} cos_af_e;
  typedef logic [`COS_PCT_W-1:0] cos_pct_t;
  typedef logic [`COS_CYC_W-1:0] cos_cyc_t;
  typedef struct packed {
    cos_pct_t lvl;
    logic pulse;
    logic loop;
  } cos_ana_s;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic forward_action, stop, onoff, heat_loop, cool_loop;
    cos_rf_e rf1, rfa1, rfa2;
    cos_af_e af2, af3;
    cos_cyc_t cyc_h, cyc_c;
    cos_pct_t lim_hi, lim_lo, pre_h, pre_c;
    logic [15:0] hys_hc, hys_up, hys_lo;
    logic hyst_heat, hyst_cool, relay1, aux1, aux2;
    cos_ana_s o2, o3;
  } cos_state_s;
  typedef struct packed {
    logic [`COS_PRE_W-1:0] pre;
    logic [`COS_CNT_W-1:0] cnt;
    cos_pct_t lvl;
    logic on;
    logic wrap;
  } cos_tp_state_s;
endpackage

// file: pkg/cos_tp_if.sv
// Carrier between the output stage and a time-proportioning generator.
// Assumes cos_consts.svh is on the include path.
`timescale 1ns/1ps
`include "cos_consts.svh"
interface cos_tp_if;
  logic [`COS_CYC_W-1:0] cycle_sec;
  logic [`COS_PCT_W-1:0] level;
  logic on;
  logic wrap;
  modport ctl (output cycle_sec, output level, input on, input wrap);
  modport gen (input cycle_sec, input level, output on, output wrap);
endinterface

// file: rtl/cos_tprop.sv
// Time-proportioning generator: one on/off pulse per cycle time.
// Assumes a 40 MHz core_clk and a level of 0 to 100 percent.
`timescale 1ns/1ps
`include "cos_consts.svh"
module cos_tprop
  import cos_pkg::*;
#(
  parameter int unsigned SLICE_CYCLES = `COS_SLICE_CYC
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  cos_tp_if.gen tp
);

  cos_tp_state_s q, d;
  logic tick;
  logic [`COS_CNT_W-1:0] period, on_time;

  ////////////////////////////////////////////////////////////////////////
  // The cycle is cut into hundredths; the level is latched only at the
  // start of a cycle so that a changing demand never splits a pulse.
  always_comb
  begin
    d = q;
    d.wrap = 1'b0;
    tick = (q.pre == `COS_PRE_W'(SLICE_CYCLES - 1));
    // Both factors are widened first: 300 s times 100 slices needs 15 bits.
    period = `COS_CNT_W'(tp.cycle_sec) * `COS_CNT_W'(`COS_SLICES);
    d.pre = tick ? '0 : q.pre + 1'b1;
    if (tick)
    begin
      if (q.cnt + 1'b1 >= period)
      begin
        d.cnt = '0;
        d.lvl = tp.level;
        d.wrap = 1'b1;
      end
      else
        d.cnt = q.cnt + 1'b1;
    end
    on_time = `COS_CNT_W'(tp.cycle_sec) * `COS_CNT_W'(d.lvl);
    d.on = (d.cnt < on_time);
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= d;
  end

  assign tp.on = q.on;
  assign tp.wrap = q.wrap;

  a_tp_start_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    q.wrap |-> q.on == (q.lvl != '0))
    else $error("pulse not on at cycle start for nonzero level");
  a_tp_full_on: assert property (@(posedge core_clk) disable iff (sys_rst)
    (q.lvl == `COS_PCT_MAX && !q.wrap) [*2] |-> q.on)
    else $error("full level pulse dropped inside cycle");
endmodule // cos_tprop

// file: rtl/cos_output_stage.sv
// Control output stage: routing, action, limits, hysteresis, presets
// and time-proportional drive of relay and analog outputs.
// Assumes a classic Wishbone master and same-clock control inputs.
//
// Operation
// - Relay one: heat/cool/alarms/run, default alarm one.
// - Cool only on H/C; frozen in on/off.
// - Output two: heat/cool/retransmit, default heat.
// - Output three same, only when fitted.
// - Heating analog drive: pulse or loop, pulse default.
// - Cooling analog drive: own pulse/loop choice.
// - Aux relay one, if fitted, default alarm two.
// - Aux relay two, if fitted, default alarm two.
// - Forward action drives hard above setpoint.
// - Reverse action, default, drives hard below setpoint.
// - Heating cycle time 1 to 300 s.
// - Cooling cycle time separate, 1 to 300 s.
// - Level outside stop or error never above high limit.
// - Level outside stop or error never below low limit, unless low limit is set above high.
// - H/C on/off uses one hysteresis band.
// - Plain on/off uses upper and lower hysteresis.
// - Stop or error forces heating preset.
// - Stop or error forces cooling preset.
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "cos_consts.svh"
module cos_output_stage
  import cos_pkg::*;
#(
  parameter bit HC_MODEL = 1'b1,
  parameter bit HAS_ANALOG_OUTPUT_THREE = 1'b1,
  parameter bit HAS_AUX1 = 1'b1,
  parameter bit HAS_AUX2 = 1'b1,
  parameter int unsigned SLICE_CYCLES = `COS_SLICE_CYC
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic signed [`COS_PV_W-1:0] process_value,
  input wire logic signed [`COS_PV_W-1:0] setpoint,
  input wire logic [`COS_PCT_W-1:0] heat_demand,
  input wire logic [`COS_PCT_W-1:0] cool_demand,
  input wire logic [`COS_PCT_W-1:0] retrans_level,
  input wire logic [2:0] alarm_active,
  input wire logic run_active,
  input wire logic algo_err,
  input wire logic adc_err,
  input wire logic open_sensor,
  output logic relay_output_one,
  output logic aux_relay_one,
  output logic aux_relay_two,
  output logic [`COS_PCT_W-1:0] analog_output_two_level,
  output logic analog_output_two_pulse,
  output logic analog_output_two_loop,
  output logic [`COS_PCT_W-1:0] analog_output_three_level,
  output logic analog_output_three_pulse,
  output logic analog_output_three_loop
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic cos_state_s rst_state();
    cos_state_s s;
    s = '0;
    s.rf1 = RF_ALARM_ONE;
    s.af2 = AF_HEAT;
    s.af3 = AF_HEAT;
    s.rfa1 = RF_ALARM_TWO;
    s.rfa2 = RF_ALARM_TWO;
    s.cyc_h = `COS_CYC_DEF;
    s.cyc_c = `COS_CYC_DEF;
    s.lim_hi = `COS_LIM_HI_DEF;
    s.lim_lo = `COS_LIM_LO_DEF;
    s.pre_h = `COS_PRESET_DEF;
    s.pre_c = `COS_PRESET_DEF;
    s.hys_hc = `COS_HYS_DEF;
    s.hys_up = `COS_HYS_DEF;
    s.hys_lo = `COS_HYS_DEF;
    return s;
  endfunction

  localparam cos_state_s RST_STATE = rst_state();

  function automatic logic rf_ok(logic [2:0] v);
    return (v <= 3'(RF_RUN)) && (HC_MODEL || v != 3'(RF_COOL));
  endfunction

  function automatic logic af_ok(logic [1:0] v);
    return (v <= 2'(AF_RETRANS)) && (HC_MODEL || v != 2'(AF_COOL));
  endfunction

  // Out of range cycle times are pulled to the nearest legal value.
  function automatic cos_cyc_t cyc_fix(cos_cyc_t v);
    if (v < `COS_CYC_MIN)
      return `COS_CYC_MIN;
    else if (v > `COS_CYC_MAX)
      return `COS_CYC_MAX;
    return v;
  endfunction

  function automatic cos_pct_t pct_fix(cos_pct_t v);
    return (v > `COS_PCT_MAX) ? `COS_PCT_MAX : v;
  endfunction

  // The high limit wins when software sets the low one above it.
  function automatic cos_pct_t clamp(cos_pct_t v, cos_pct_t lo,
                                     cos_pct_t hi);
    cos_pct_t m;
    m = (v < lo) ? lo : v;
    return (m > hi) ? hi : m;
  endfunction

  function automatic logic relay_fn(cos_rf_e f, logic h, logic c,
                                    logic [2:0] a, logic r);
    case (f)
      RF_HEAT: return h;
      RF_COOL: return c;
      RF_ALARM_ONE: return a[0];
      RF_ALARM_TWO: return a[1];
      RF_ALARM_THREE: return a[2];
      default: return r;
    endcase
  endfunction

  function automatic cos_ana_s ana_fn(cos_af_e f, cos_pct_t hl,
    cos_pct_t cl, cos_pct_t rl, logic hon, logic con, logic hlp,
    logic clp);
    cos_ana_s a;
    case (f)
      AF_HEAT: a = '{hl, hon & ~hlp, hlp};
      AF_COOL: a = '{cl, con & ~clp, clp};
      default: a = '{rl, 1'b0, 1'b1};
    endcase
    return a;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] sel);
    logic [31:0] r;
    for (int i = 0; i < 4; i++)
      r[i*8 +: 8] = sel[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State and datapath.
  cos_state_s q, d;
  cos_tp_if tp [2] ();
  logic fault, hold, req, heat_on, cool_on;
  logic signed [`COS_PV_W:0] dev;
  logic [15:0] thr_up, thr_lo;
  cos_pct_t heat_level, cool_level;
  logic [31:0] rd, w;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_tp
      cos_tprop #(.SLICE_CYCLES(SLICE_CYCLES)) u_tp (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .tp(tp[gi])
      );
    end
  endgenerate

  assign tp[0].cycle_sec = q.cyc_h;
  assign tp[0].level = heat_level;
  assign tp[1].cycle_sec = q.cyc_c;
  assign tp[1].level = cool_level;

  always_comb
  begin
    d = q;
    d.ack = 1'b0;
    fault = algo_err | adc_err | open_sensor;
    hold = fault | q.stop;
    // Positive deviation always means the heating side should act.
    if (q.forward_action)
      dev = {process_value[15], process_value} - {setpoint[15], setpoint};
    else
      dev = {setpoint[15], setpoint} - {process_value[15], process_value};
    thr_up = HC_MODEL ? q.hys_hc : q.hys_up;
    thr_lo = HC_MODEL ? q.hys_hc : q.hys_lo;
    if (dev >= $signed({1'b0, thr_lo}))
      d.hyst_heat = 1'b1;
    else if (dev <= -$signed({1'b0, thr_up}))
      d.hyst_heat = 1'b0;
    if (!HC_MODEL)
      d.hyst_cool = 1'b0;
    else if (-dev >= $signed({1'b0, q.hys_hc}))
      d.hyst_cool = 1'b1;
    else if (-dev <= -$signed({1'b0, q.hys_hc}))
      d.hyst_cool = 1'b0;

    if (hold)
      heat_level = q.pre_h;
    else if (q.onoff)
      heat_level = clamp(q.hyst_heat ? `COS_PCT_MAX : '0, q.lim_lo,
                         q.lim_hi);
    else
      heat_level = clamp(heat_demand, q.lim_lo, q.lim_hi);
    if (!HC_MODEL)
      cool_level = '0;
    else if (hold)
      cool_level = q.pre_c;
    else if (q.onoff)
      cool_level = clamp(q.hyst_cool ? `COS_PCT_MAX : '0, q.lim_lo,
                         q.lim_hi);
    else
      cool_level = clamp(cool_demand, q.lim_lo, q.lim_hi);
    // On/off control switches directly; presets always go through the
    // time-proportioning generator so a fault never latches full power.
    heat_on = (q.onoff && !hold) ? q.hyst_heat : tp[0].on;
    cool_on = HC_MODEL && ((q.onoff && !hold) ? q.hyst_cool : tp[1].on);

    d.relay1 = relay_fn(q.rf1, heat_on, cool_on, alarm_active,
                        run_active);
    d.aux1 = HAS_AUX1 && relay_fn(q.rfa1, heat_on, cool_on, alarm_active,
                                  run_active);
    d.aux2 = HAS_AUX2 && relay_fn(q.rfa2, heat_on, cool_on, alarm_active,
                                  run_active);
    d.o2 = ana_fn(q.af2, heat_level, cool_level, retrans_level, heat_on,
                  cool_on, q.heat_loop, q.cool_loop);
    d.o3 = HAS_ANALOG_OUTPUT_THREE ? ana_fn(q.af3, heat_level, cool_level, retrans_level,
                             heat_on, cool_on, q.heat_loop, q.cool_loop)
                    : '0;

    ////////////////////////////////////////////////////////////////////
    // Register read decode.
    rd = '0;
    if (wb_adr_i == `COS_A_CTRL)
    begin
      rd[`COS_F_FWD] = q.forward_action;
      rd[`COS_F_STOP] = q.stop;
      rd[`COS_F_ONOFF] = q.onoff;
    end
    else if (wb_adr_i == `COS_A_FUNC)
    begin
      rd[`COS_F_RF1 +: 3] = q.rf1;
      rd[`COS_F_AF2 +: 2] = q.af2;
      rd[`COS_F_AF3 +: 2] = HAS_ANALOG_OUTPUT_THREE ? q.af3 : AF_HEAT;
      rd[`COS_F_RFA1 +: 3] = q.rfa1;
      rd[`COS_F_RFA2 +: 3] = q.rfa2;
      rd[`COS_F_HLOOP] = q.heat_loop;
      rd[`COS_F_CLOOP] = q.cool_loop;
    end
    else if (wb_adr_i == `COS_A_CYCLE)
    begin
      rd[0 +: `COS_CYC_W] = q.cyc_h;
      rd[`COS_F_CYC_C +: `COS_CYC_W] = q.cyc_c;
    end
    else if (wb_adr_i == `COS_A_LIMIT)
    begin
      rd[`COS_F_HI +: `COS_PCT_W] = q.lim_hi;
      rd[`COS_F_LO +: `COS_PCT_W] = q.lim_lo;
    end
    else if (wb_adr_i == `COS_A_HYS_HC)
      rd[15:0] = q.hys_hc;
    else if (wb_adr_i == `COS_A_HYS_LIM)
      rd = {q.hys_lo, q.hys_up};
    else if (wb_adr_i == `COS_A_PRESET)
    begin
      rd[0 +: `COS_PCT_W] = q.pre_h;
      rd[`COS_F_PRE_C +: `COS_PCT_W] = q.pre_c;
    end
    else if (wb_adr_i == `COS_A_STATUS)
    begin
      rd[5:0] = {hold, cool_on, heat_on, q.aux2, q.aux1, q.relay1};
      rd[`COS_F_ST_LVH +: `COS_PCT_W] = heat_level;
      rd[`COS_F_ST_LVC +: `COS_PCT_W] = cool_level;
    end

    ////////////////////////////////////////////////////////////////////
    // Register write decode; illegal codes leave the field unchanged.
    req = wb_cyc_i && wb_stb_i && !q.ack;
    w = merge(rd, wb_dat_i, wb_sel_i);
    if (req)
    begin
      d.ack = 1'b1;
      d.dat = rd;
    end
    if (req && wb_we_i)
    begin
      if (wb_adr_i == `COS_A_CTRL)
      begin
        d.forward_action = w[`COS_F_FWD];
        d.stop = w[`COS_F_STOP];
        d.onoff = w[`COS_F_ONOFF];
      end
      else if (wb_adr_i == `COS_A_FUNC)
      begin
        if (!q.onoff && rf_ok(w[`COS_F_RF1 +: 3]))
          d.rf1 = cos_rf_e'(w[`COS_F_RF1 +: 3]);
        if (af_ok(w[`COS_F_AF2 +: 2]))
          d.af2 = cos_af_e'(w[`COS_F_AF2 +: 2]);
        if (HAS_ANALOG_OUTPUT_THREE && af_ok(w[`COS_F_AF3 +: 2]))
          d.af3 = cos_af_e'(w[`COS_F_AF3 +: 2]);
        if (HAS_AUX1 && rf_ok(w[`COS_F_RFA1 +: 3]))
          d.rfa1 = cos_rf_e'(w[`COS_F_RFA1 +: 3]);
        if (HAS_AUX2 && rf_ok(w[`COS_F_RFA2 +: 3]))
          d.rfa2 = cos_rf_e'(w[`COS_F_RFA2 +: 3]);
        d.heat_loop = w[`COS_F_HLOOP];
        d.cool_loop = w[`COS_F_CLOOP];
      end
      else if (wb_adr_i == `COS_A_CYCLE)
      begin
        d.cyc_h = cyc_fix(w[0 +: `COS_CYC_W]);
        d.cyc_c = cyc_fix(w[`COS_F_CYC_C +: `COS_CYC_W]);
      end
      else if (wb_adr_i == `COS_A_LIMIT)
      begin
        d.lim_hi = pct_fix(w[`COS_F_HI +: `COS_PCT_W]);
        d.lim_lo = pct_fix(w[`COS_F_LO +: `COS_PCT_W]);
      end
      else if (wb_adr_i == `COS_A_HYS_HC)
        d.hys_hc = w[15:0];
      else if (wb_adr_i == `COS_A_HYS_LIM)
      begin
        d.hys_up = w[`COS_F_HYS_UP +: 16];
        d.hys_lo = w[`COS_F_HYS_LO +: 16];
      end
      else if (wb_adr_i == `COS_A_PRESET)
      begin
        d.pre_h = pct_fix(w[0 +: `COS_PCT_W]);
        d.pre_c = pct_fix(w[`COS_F_PRE_C +: `COS_PCT_W]);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      q <= RST_STATE;
    else
      q <= d;
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign relay_output_one = q.relay1;
  assign aux_relay_one = q.aux1;
  assign aux_relay_two = q.aux2;
  assign analog_output_two_level = q.o2.lvl;
  assign analog_output_two_pulse = q.o2.pulse;
  assign analog_output_two_loop = q.o2.loop;
  assign analog_output_three_level = q.o3.lvl;
  assign analog_output_three_pulse = q.o3.pulse;
  assign analog_output_three_loop = q.o3.loop;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_reset_defaults: assert property ($fell(sys_rst) |->
    q.rf1 == RF_ALARM_ONE && q.rfa1 == RF_ALARM_TWO &&
    q.rfa2 == RF_ALARM_TWO && q.af2 == AF_HEAT && !q.forward_action &&
    q.cyc_h == `COS_CYC_DEF && !q.heat_loop)
    else $error("reset defaults wrong");
  a_relay_frozen: assert property (req && wb_we_i && q.onoff &&
    wb_adr_i == `COS_A_FUNC |=> $stable(q.rf1))
    else $error("relay one function changed in on/off mode");
  a_no_cool_plain: assert property (!HC_MODEL |->
    q.af2 != AF_COOL && q.rf1 != RF_COOL && !cool_on)
    else $error("cooling used on plain model");
  a_analog_output_three_absent: assert property (!HAS_ANALOG_OUTPUT_THREE |->
    analog_output_three_level == '0 && !analog_output_three_pulse)
    else $error("missing output three driven");
  a_heat_drive: assert property (q.af2 == AF_HEAT |=>
    analog_output_two_loop == $past(q.heat_loop) &&
    analog_output_two_level == $past(heat_level))
    else $error("heating drive form wrong");
  a_fwd_action: assert property (q.onoff && q.forward_action &&
    process_value > setpoint + $signed({1'b0, thr_lo}) && !hold
    ##1 q.onoff && q.forward_action && !hold |-> heat_on)
    else $error("forward action not driving above setpoint");
  a_rev_action: assert property (q.onoff && !q.forward_action &&
    dev <= -$signed({1'b0, thr_up}) ##1 q.onoff && !hold |-> !heat_on)
    else $error("reverse action driving above setpoint");
  a_cycle_range: assert property (q.cyc_h >= `COS_CYC_MIN &&
    q.cyc_h <= `COS_CYC_MAX && q.cyc_c >= `COS_CYC_MIN &&
    q.cyc_c <= `COS_CYC_MAX)
    else $error("cycle time out of range");
  a_level_clamp: assert property (!hold |-> heat_level <= q.lim_hi &&
    (heat_level >= q.lim_lo || q.lim_lo > q.lim_hi))
    else $error("heating level outside limits");
  a_preset_hold: assert property (hold |-> heat_level == q.pre_h &&
    (!HC_MODEL || cool_level == q.pre_c))
    else $error("preset not applied in stop or error");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_fault_recover: cover property (fault ##1 !fault);
  c_heat_cycle: cover property (tp[0].wrap ##[1:300] tp[0].on);
  c_onoff_heat: cover property (q.onoff && $rose(q.hyst_heat));
  c_stop_mode: cover property ($rose(q.stop));
endmodule // cos_output_stage

// file: verif/cos_load_model.sv
// Behavioural load on a pulse-driven output: counts heated clocks.
// Assumes the drive pin is registered on the rising edge of core_clk.
`timescale 1ns/1ps
module cos_load_model
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic drive_on,
  input wire logic loop_sel,
  output logic [31:0] on_clks
);
  // A current-loop actuator ignores the pulse pin, so it adds no energy.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      on_clks <= 32'h0;
    else if (drive_on && !loop_sel)
      on_clks <= on_clks + 32'h1;
  end
endmodule // cos_load_model

// file: verif/tb_control_output_stage.sv
// Self-checking bench of the control output stage with two loads.
// Assumes cos_consts.svh on the include path and a 40 MHz clock.
`timescale 1ns/1ps
`include "cos_consts.svh"
module tb_control_output_stage;
  import cos_pkg::*;
  logic core_clk, sys_rst, wb_we, wb_cyc, wb_stb, run_active, wb_ack_o;
  logic algo_err, adc_err, open_sensor, relay1, aux1, aux2;
  logic o2_p, o2_l, o3_p, o3_l;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [2:0] alarm_active;
  logic [31:0] wb_dat, wb_dat_o, q, f, a2, a3, b2, b3;
  logic signed [15:0] pv, sp;
  logic [6:0] hd, cd, rl, o2_lvl, o3_lvl, hi, lo, ph, pc;
  int num_errors, cmp_count;
  int devs[5] = '{-60, 30, 60, -30, -60};
  logic ex[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  int lv[3] = '{0, 37, 100};
  cos_output_stage #(.SLICE_CYCLES(4)) cos_output_stage_inst (.core_clk,
    .sys_rst, .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
    .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o,
    .wb_ack_o, .process_value(pv), .setpoint(sp), .heat_demand(hd),
    .cool_demand(cd), .retrans_level(rl), .alarm_active, .run_active,
    .algo_err, .adc_err, .open_sensor, .relay_output_one(relay1),
    .aux_relay_one(aux1), .aux_relay_two(aux2),
    .analog_output_two_level(o2_lvl), .analog_output_two_pulse(o2_p),
    .analog_output_two_loop(o2_l), .analog_output_three_level(o3_lvl),
    .analog_output_three_pulse(o3_p), .analog_output_three_loop(o3_l));
  cos_load_model load2_inst (.core_clk, .sys_rst, .drive_on(o2_p),
    .loop_sel(o2_l), .on_clks(b2));
  cos_load_model load3_inst (.core_clk, .sys_rst, .drive_on(o3_p),
    .loop_sel(o3_l), .on_clks(b3));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // The request stays up until ack is seen, whatever the latency.
  task automatic xfer(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    wb_adr <= a;
    wb_we <= w;
    wb_dat <= d;
    wb_sel <= 4'hf;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask
  function automatic logic [6:0] clamp(logic [6:0] d, logic [6:0] l,
    logic [6:0] h);
    logic [6:0] r;
    r = (d < l) ? l : d;
    return (r > h) ? h : r;
  endfunction
  function automatic logic relay_exp(int c);
    return (c == 5) ? run_active : alarm_active[c - 2];
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge core_clk);
    num_errors++;
    conclude();
  end
  initial
  begin
    {wb_we, wb_cyc, wb_stb, run_active, algo_err, adc_err} = '0;
    {open_sensor, alarm_active, wb_adr, wb_sel, wb_dat} = '0;
    {pv, sp, hd, cd, rl} = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    void'($urandom(26));
    @(posedge core_clk);
    rd_chk(`COS_A_FUNC, 32'h00003302);
    rd_chk(`COS_A_CTRL, 32'h0);
    rd_chk(`COS_A_CYCLE, 32'h00020002);
    rd_chk(`COS_A_LIMIT, 32'h00000064);
    rd_chk(`COS_A_HYS_LIM, 32'h00010001);
    wr(`COS_A_CYCLE, 32'h0000012d);
    rd_chk(`COS_A_CYCLE, 32'h0001012c);
    wr(8'h20, 32'hffffffff);
    rd_chk(8'h20, 32'h0);
    for (int c = 0; c < 6; c++)
    begin
      f = 32'(c) | (32'(c) << 8) | (32'(c) << 12);
      wr(`COS_A_FUNC, f);
      rd_chk(`COS_A_FUNC, f);
      for (int i = 0; i < 4 && c >= 2; i++)
      begin
        alarm_active <= 3'($urandom);
        run_active <= 1'($urandom);
        settle();
        chk(relay1, relay_exp(c));
        chk(aux1, relay_exp(c));
        chk(aux2, relay_exp(c));
      end
    end
    wr(`COS_A_FUNC, 32'h00033342);
    for (int i = 0; i < 8; i++)
    begin
      hi = 7'(50 + $urandom % 51);
      lo = 7'($urandom % 50);
      hd <= 7'($urandom % 101);
      cd <= 7'($urandom % 101);
      wr(`COS_A_LIMIT, 32'(hi) | (32'(lo) << 8));
      settle();
      chk(o2_lvl, clamp(hd, lo, hi));
      chk(o2_l, 1'b1);
      chk(o3_lvl, clamp(cd, lo, hi));
      chk(o3_l, 1'b1);
    end
    for (int k = 0; k < 4; k++)
    begin
      ph = 7'($urandom % 101);
      pc = 7'($urandom % 101);
      wr(`COS_A_PRESET, 32'(ph) | (32'(pc) << 8));
      if (k == 0)
        wr(`COS_A_CTRL, 32'h2);
      {open_sensor, adc_err, algo_err} <= 3'((1 << k) >> 1);
      settle();
      chk(o2_lvl, ph);
      chk(o3_lvl, pc);
      xfer(`COS_A_STATUS, 1'b0, 32'h0);
      f = 32'h20 | (32'(ph) << 8) | (32'(pc) << 16);
      chk(q & 32'h007f7f20, f);
      wr(`COS_A_CTRL, 32'h0);
      {open_sensor, adc_err, algo_err} <= 3'h0;
    end
    rl <= 7'($urandom % 101);
    wr(`COS_A_FUNC, 32'h00003322);
    settle();
    chk(o2_l, 1'b1);
    chk(o2_lvl, rl);
    chk(o2_p, 1'b0);
    // Heating runs at 1 s and cooling at 3 s, so one 3 s window fits both.
    wr(`COS_A_LIMIT, 32'h00000064);
    wr(`COS_A_FUNC, 32'h00003342);
    wr(`COS_A_CYCLE, 32'h00030001);
    foreach (lv[i])
    begin
      hd <= 7'(lv[i]);
      cd <= 7'(lv[i]);
      repeat (2400) @(posedge core_clk);
      a2 = b2;
      a3 = b3;
      repeat (1200) @(posedge core_clk);
      chk(b2 - a2, 32'(12 * lv[i]));
      chk(b3 - a3, 32'(12 * lv[i]));
    end
    wr(`COS_A_FUNC, 32'h00003300);
    wr(`COS_A_HYS_HC, 32'd50);
    wr(`COS_A_CTRL, 32'h4);
    wr(`COS_A_FUNC, 32'h00003304);
    rd_chk(`COS_A_FUNC, 32'h00003300);
    sp <= 16'sd1000;
    foreach (devs[i])
    begin
      pv <= 16'(1000 - devs[i]);
      settle();
      chk(relay1, ex[i]);
    end
    wr(`COS_A_CTRL, 32'h5);
    pv <= 16'sd1100;
    settle();
    chk(relay1, 1'b1);
    pv <= 16'sd900;
    settle();
    chk(relay1, 1'b0);
    conclude();
  end
endmodule // tb_control_output_stage
